// ==== tpm_pkg.sv ====
// Constants, register map and carrier types of the pulse measure/PULSE_OUT_PIN timer.
// Assumes one 100 MHz clock and a single-cycle register port.
// Summary of operation
// - Measure: count starts at trigger edge, then ticks on source clock.
// - Start field picks rising or falling input edge as trigger.
// - Capture-mode bit: 1 single-edge capture, 0 double-edge capture.
// - Single: opposite edge captures, interrupts, sets count to 1; trigger resumes.
// - Single: counter rests at 1 after capture until next edge.
// - Double: capture on opposite edge; on trigger capture again, clear.
// - Generation: start on input edge or at once by command.
// - Repeat bit: 0 continuous pulse train, 1 one-shot.
// - Continuous: B match toggles, interrupts; A match also clears count.
// - Stopping by start field 00 keeps the output level.
// - One-shot: A match toggles, interrupts, stops timer, holds level.
// - Output pin is inverse of output flop, whose load bit sets polarity.
// - Reset clears the output flop.
// - Flop bit loads only on a generation-mode write while stopped, before the timer has run.
// - Stop power mode clears start field and halts the timer.
package tpm_pkg;

  localparam int CNT_W = 16;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int DIV_W = 8;
  localparam int SYNC_STAGES = 2;

  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CMPA = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CMPB = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;

  // Control word layout, low bit first
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_START_LSB = 2;
  localparam int CTRL_CAP_BIT = 4;
  localparam int CTRL_REP_BIT = 5;
  localparam int CTRL_TFF_BIT = 6;
  localparam int CTRL_CLK_LSB = 7;
  localparam int CTRL_W = 9;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 9'h000;
  localparam logic [CNT_W-1:0] CMP_RESET = 16'h0000;

  // Status word layout
  localparam int STAT_ARM_BIT = 0;
  localparam int STAT_RUN_BIT = 1;
  localparam int STAT_PIN_BIT = 2;
  localparam int STAT_W = 3;

  localparam logic [1:0] MODE_TIMER = 2'h0;
  localparam logic [1:0] MODE_MEAS = 2'h1;
  localparam logic [1:0] MODE_PPG = 2'h2;

  localparam logic [1:0] START_STOP = 2'h0;
  localparam logic [1:0] START_CMD = 2'h1;
  localparam logic [1:0] START_RISE = 2'h2;
  localparam logic [1:0] START_FALL = 2'h3;

  // Source clock tick masks: divide by 1, 2, 16, 128
  localparam logic [3:0][DIV_W-1:0] DIV_MASK = {8'h7F, 8'h0F, 8'h01, 8'h00};

  typedef struct packed {
    logic [1:0] clk_sel;
    logic out_flop_init;
    logic pulse_repeat_select;
    logic capture_edge_mode;
    logic [1:0] start_edge_select;
    logic [1:0] timer_mode_field;
  } tpm_ctrl_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } tpm_bus_req_t;

  typedef enum logic [1:0] {ST_STOP, ST_ARM, ST_RUN} tpm_state_t;

endpackage

// ==== tpm_edge_sync.sv ====
// Pin synchroniser with rising and falling edge pulses.
// Assumes an asynchronous pin and one clock domain.
`timescale 1ns/1ps
module tpm_edge_sync #(
  parameter int STAGES = 2
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic pin,
  output logic rise,
  output logic fall
);

  logic [STAGES-1:0] sync_q;
  logic prev_q;

  if (STAGES < 2) begin : g_bad_stages
    $error("tpm_edge_sync needs at least two stages");
  end

  // Only the last stage and its delayed copy feed the edge logic
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync_q <= '0;
      prev_q <= 1'b0;
    end else begin
      sync_q <= {sync_q[STAGES-2:0], pin};
      prev_q <= sync_q[STAGES-1];
    end
  end

  assign rise = sync_q[STAGES-1] & ~prev_q;
  assign fall = ~sync_q[STAGES-1] & prev_q;

endmodule // tpm_edge_sync

// ==== tpm_top.sv ====
// Pulse width measurement and programmable pulse generation timer.
// Assumes a register master on clk_sys and an asynchronous input pin.
`timescale 1ns/1ps
module tpm_top
  import tpm_pkg::*;
#(
  parameter int CW = CNT_W
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire tpm_bus_req_t bus_req,
  input wire logic stop_mode_req,
  input wire logic timer_input_pin,
  output logic [DATA_W-1:0] rdata,
  output logic timer_irq,
  output logic pulse_out_pin
);

  if (CW < 2 || CW > DATA_W) begin : g_bad_width
    $error("tpm_top counter width out of range");
  end

  tpm_ctrl_t ctrl_q;
  tpm_ctrl_t ctrl_d;
  tpm_state_t st_q;
  tpm_state_t st_d;
  logic [CW-1:0] cmpa_q;
  logic [CW-1:0] cmpb_q;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic [DIV_W-1:0] div_q;
  logic tff_q;
  logic tff_d;
  logic ran_q;
  logic ran_d;
  logic pin_q;
  logic irq_q;
  logic irq_d;
  logic [DATA_W-1:0] rdata_q;
  logic cap_en;
  logic tog;
  logic shot_end;
  logic in_rise;
  logic in_fall;

  tpm_edge_sync #(
    .STAGES(SYNC_STAGES)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .pin(timer_input_pin),
    .rise(in_rise),
    .fall(in_fall)
  );

  // Register decode
  wire wr_ctrl = bus_req.wr && (bus_req.addr == OFS_CTRL);
  wire wr_cmpa = bus_req.wr && (bus_req.addr == OFS_CMPA);
  wire wr_cmpb = bus_req.wr && (bus_req.addr == OFS_CMPB);
  wire tpm_ctrl_t wr_val = tpm_ctrl_t'(bus_req.wdata[CTRL_W-1:0]);
  wire [CW-1:0] wr_cnt = bus_req.wdata[CW-1:0];

  // Mode and edge selection
  wire is_meas = ctrl_q.timer_mode_field == MODE_MEAS;
  wire is_ppg = ctrl_q.timer_mode_field == MODE_PPG;
  wire single_cap = ctrl_q.capture_edge_mode;
  wire one_shot = ctrl_q.pulse_repeat_select;
  wire fall_sel = ctrl_q.start_edge_select == START_FALL;
  wire trig = fall_sel ? in_fall : in_rise;
  wire opp = fall_sel ? in_rise : in_fall;
  wire stopped = (ctrl_q.start_edge_select == START_STOP) ||
                 !(is_meas || is_ppg);
  wire cmd_start = is_ppg && (ctrl_q.start_edge_select == START_CMD);
  wire [DIV_W-1:0] div_mask = DIV_MASK[ctrl_q.clk_sel];
  wire tick = (div_q & div_mask) == div_mask;
  wire hit_a = cnt_q == cmpa_q;
  wire hit_b = cnt_q == cmpb_q;
  wire [CW-1:0] cnt_inc = cnt_q + 1'b1;

  // Read selection
  wire [STAT_W-1:0] status = {pin_q, st_q == ST_RUN, st_q == ST_ARM};
  wire [DATA_W-1:0] rd_ctrl = DATA_W'(ctrl_q);
  wire [DATA_W-1:0] rd_cmpa = DATA_W'(cmpa_q);
  wire [DATA_W-1:0] rd_cmpb = DATA_W'(cmpb_q);
  wire [DATA_W-1:0] rd_cnt = DATA_W'(cnt_q);
  wire [DATA_W-1:0] rd_stat = DATA_W'(status);
  wire [DATA_W-1:0] rd_sel =
    (bus_req.addr == OFS_CTRL) ? rd_ctrl :
    (bus_req.addr == OFS_CMPA) ? rd_cmpa :
    (bus_req.addr == OFS_CMPB) ? rd_cmpb :
    (bus_req.addr == OFS_COUNT) ? rd_cnt :
    (bus_req.addr == OFS_STATUS) ? rd_stat : '0;
  wire [DATA_W-1:0] rdata_d = bus_req.rd ? rd_sel : '0;

  // Counter sequencing
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    cap_en = 1'b0;
    irq_d = 1'b0;
    tog = 1'b0;
    shot_end = 1'b0;
    if (stopped || stop_mode_req) begin
      st_d = ST_STOP;
      cnt_d = '0;
    end else begin
      unique case (st_q)
        ST_STOP: begin
          st_d = cmd_start ? ST_RUN : ST_ARM;
        end
        ST_ARM: begin
          if (trig) begin
            st_d = ST_RUN;
          end
        end
        ST_RUN: begin
          if (is_meas) begin
            if (opp) begin
              cap_en = 1'b1;
              irq_d = 1'b1;
              if (single_cap) begin
                cnt_d = CW'(1);
                st_d = ST_ARM;
              end else if (tick) begin
                cnt_d = cnt_inc;
              end
            end else if (trig && !single_cap) begin
              cap_en = 1'b1;
              irq_d = 1'b1;
              cnt_d = '0;
            end else if (tick) begin
              cnt_d = cnt_inc;
            end
          end else if (tick) begin
            if (hit_a) begin
              tog = 1'b1;
              irq_d = 1'b1;
              cnt_d = '0;
              if (one_shot) begin
                shot_end = 1'b1;
                st_d = ST_STOP;
              end
            end else begin
              tog = hit_b;
              irq_d = hit_b;
              cnt_d = cnt_inc;
            end
          end
        end
        default: begin
          st_d = ST_STOP;
        end
      endcase
    end
  end

  // Control register and output flop
  always_comb begin
    ctrl_d = ctrl_q;
    tff_d = tff_q;
    ran_d = ran_q;
    if (wr_ctrl) begin
      ctrl_d = wr_val;
    end
    if (shot_end || stop_mode_req) begin
      ctrl_d.start_edge_select = START_STOP;
    end
    if (!is_ppg) begin
      tff_d = 1'b0;
      ran_d = 1'b0;
    end else if (st_q == ST_RUN) begin
      ran_d = 1'b1;
    end
    if (wr_ctrl && wr_val.timer_mode_field == MODE_PPG &&
        st_q == ST_STOP && !ran_q) begin
      tff_d = wr_val.out_flop_init;
    end
    if (tog) begin
      tff_d = ~tff_q;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_q <= tpm_ctrl_t'(CTRL_RESET);
      st_q <= ST_STOP;
      cnt_q <= '0;
      div_q <= '0;
      tff_q <= 1'b0;
      ran_q <= 1'b0;
      pin_q <= 1'b1;
      irq_q <= 1'b0;
      rdata_q <= '0;
    end else begin
      ctrl_q <= ctrl_d;
      st_q <= st_d;
      cnt_q <= cnt_d;
      div_q <= div_q + 1'b1;
      tff_q <= tff_d;
      ran_q <= ran_d;
      pin_q <= ~tff_d;
      irq_q <= irq_d;
      rdata_q <= rdata_d;
    end
  end

  // Compare A, and compare B shared with the capture path
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cmpa_q <= CMP_RESET;
      cmpb_q <= CMP_RESET;
    end else begin
      if (wr_cmpa) begin
        cmpa_q <= wr_cnt;
      end
      if (cap_en) begin
        cmpb_q <= cnt_q;
      end else if (wr_cmpb) begin
        cmpb_q <= wr_cnt;
      end
    end
  end

  assign rdata = rdata_q;
  assign timer_irq = irq_q;
  assign pulse_out_pin = pin_q;

  // Checks
  a_arm_count_holds: assert property (
    @(posedge clk_sys) disable iff (rst)
    (st_q == ST_ARM && !stopped && !stop_mode_req && !trig)
      |=> $stable(cnt_q))
    else $error("counter moved while waiting for trigger");

  a_meas_count_tick: assert property (
    @(posedge clk_sys) disable iff (rst)
    (st_q == ST_RUN && is_meas && !stopped && !stop_mode_req &&
     tick && !trig && !opp)
      |=> cnt_q == CW'($past(cnt_q) + 1'b1))
    else $error("counter missed a source clock tick");

  a_single_capture: assert property (
    @(posedge clk_sys) disable iff (rst)
    (st_q == ST_RUN && is_meas && single_cap && opp &&
     !stopped && !stop_mode_req)
      |=> cmpb_q == $past(cnt_q) && timer_irq && cnt_q == CW'(1) &&
          st_q == ST_ARM)
    else $error("single edge capture went wrong");

  a_single_rest_one: assert property (
    @(posedge clk_sys) disable iff (rst)
    (st_q == ST_ARM && is_meas && single_cap && cnt_q == CW'(1) &&
     !stop_mode_req && !stopped && trig)
      |=> st_q == ST_RUN && cnt_q == CW'(1))
    else $error("counter did not resume from one");

  a_double_restart: assert property (
    @(posedge clk_sys) disable iff (rst)
    (st_q == ST_RUN && is_meas && !single_cap && trig && !opp &&
     !stopped && !stop_mode_req)
      |=> cnt_q == '0 && timer_irq && cmpb_q == $past(cnt_q) &&
          st_q == ST_RUN)
    else $error("double edge trigger capture went wrong");

  a_ppg_b_toggle: assert property (
    @(posedge clk_sys) disable iff (rst)
    (st_q == ST_RUN && is_ppg && tick && hit_b && !hit_a &&
     !stopped && !stop_mode_req)
      |=> pulse_out_pin != $past(pulse_out_pin) && timer_irq)
    else $error("compare B match did not toggle output");

  a_one_shot_end: assert property (
    @(posedge clk_sys) disable iff (rst)
    (st_q == ST_RUN && is_ppg && one_shot && tick && hit_a &&
     !stopped && !stop_mode_req)
      |=> ctrl_q.start_edge_select == START_STOP && timer_irq
      ##1 st_q == ST_STOP && $stable(pulse_out_pin))
    else $error("one shot did not stop and hold");

  a_stop_holds_pin: assert property (
    @(posedge clk_sys) disable iff (rst)
    (is_ppg && stopped && !wr_ctrl) [*2] |=> $stable(pulse_out_pin))
    else $error("stopped output changed level");

  a_pin_inverse: assert property (
    @(posedge clk_sys) disable iff (rst)
    pulse_out_pin == !tff_q)
    else $error("output pin is not the inverse of the flop");

  a_stop_mode: assert property (
    @(posedge clk_sys) disable iff (rst)
    stop_mode_req |=> ctrl_q.start_edge_select == START_STOP &&
                      st_q == ST_STOP && cnt_q == '0)
    else $error("stop power mode did not halt the timer");

  a_double_opp_count: assert property (
    @(posedge clk_sys) disable iff (rst)
    (st_q == ST_RUN && is_meas && !single_cap && opp && tick &&
     !stopped && !stop_mode_req)
      |=> cnt_q == CW'($past(cnt_q) + 1'b1) && timer_irq &&
          cmpb_q == $past(cnt_q) && st_q == ST_RUN)
    else $error("double edge capture stopped the counter");

  a_cmd_start: assert property (
    @(posedge clk_sys) disable iff (rst)
    (st_q == ST_STOP && cmd_start && !stopped && !stop_mode_req)
      |=> st_q == ST_RUN)
    else $error("command start did not run the timer");

  a_ppg_a_clear: assert property (
    @(posedge clk_sys) disable iff (rst)
    (st_q == ST_RUN && is_ppg && !one_shot && tick && hit_a &&
     !stopped && !stop_mode_req)
      |=> cnt_q == '0 && timer_irq && st_q == ST_RUN &&
          pulse_out_pin != $past(pulse_out_pin))
    else $error("compare A match did not clear and toggle");

endmodule // tpm_top

// ==== tpm_pulse_src.sv ====
// Partner model: external pulse source feeding the timer input pin.
// Assumes the bench clock; edges land 3 ns after a rising clock edge.
`timescale 1ns/1ps
module tpm_pulse_src (
  input wire logic clk_sys,
  input wire logic run,
  input wire logic [15:0] hi_cyc,
  input wire logic [15:0] lo_cyc,
  output logic pin
);
  int n;
  initial begin
    pin = 1'b0;
    n = 0;
    forever begin
      @(posedge clk_sys);
      if (!run) begin
        pin <= #3 1'b0;
        n = 0;
      end else begin
        // Each period opens with its high level
        pin <= #3 (n < hi_cyc);
        n = (n + 1 >= hi_cyc + lo_cyc) ? 0 : n + 1;
      end
    end
  end
endmodule // tpm_pulse_src

// ==== tpm_bench.sv ====
// Self-checking bench for the measure/PULSE_OUT_PIN timer.
// Assumes tpm_pkg, tpm_top and tpm_pulse_src are compiled first.
`timescale 1ns/1ps
module tpm_bench;
  import tpm_pkg::*;
  localparam int DIVS [4] = '{1, 2, 16, 128};
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  tpm_bus_req_t bus_req = '0;
  logic stop_mode_req = 1'b0;
  logic timer_input_pin;
  logic [DATA_W-1:0] rdata;
  logic timer_irq;
  logic pulse_out_pin;
  logic src_run = 1'b0;
  logic [15:0] hi_cyc = 16'h0010;
  logic [15:0] lo_cyc = 16'h0028;
  int n_fail = 0;
  int total_checks = 0;
  logic [31:0] v;
  logic [31:0] cap [5];
  int dur;
  int a;
  int b;
  int exp_q[$];

  tpm_top dut (.clk_sys(clk_sys), .rst(rst), .bus_req(bus_req),
    .stop_mode_req(stop_mode_req), .timer_input_pin(timer_input_pin),
    .rdata(rdata), .timer_irq(timer_irq), .pulse_out_pin(pulse_out_pin));
  tpm_pulse_src src (.clk_sys(clk_sys), .run(src_run), .hi_cyc(hi_cyc),
    .lo_cyc(lo_cyc), .pin(timer_input_pin));

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: saw %0h, want %0h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk_sys);
    bus_req.addr <= ad;
    bus_req.wdata <= d;
    bus_req.wr <= 1'b1;
    @(posedge clk_sys);
    bus_req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] ad, output logic [31:0] d);
    @(posedge clk_sys);
    bus_req.addr <= ad;
    bus_req.rd <= 1'b1;
    @(posedge clk_sys);
    bus_req.rd <= 1'b0;
    #1 d = rdata;
  endtask

  function automatic logic [31:0] cw(input int md, st, cp, rp, tf, ck);
    return (32'(md) << CTRL_MODE_LSB) | (32'(st) << CTRL_START_LSB) |
      (32'(cp) << CTRL_CAP_BIT) | (32'(rp) << CTRL_REP_BIT) |
      (32'(tf) << CTRL_TFF_BIT) | (32'(ck) << CTRL_CLK_LSB);
  endfunction

  task automatic wait_irq();
    int i;
    i = 0;
    do begin
      @(posedge clk_sys);
      #1 i++;
    end while (timer_irq !== 1'b1 && i < 3000);
    if (i >= 3000) chk(32'h0, 32'h1);
  endtask

  // Cycles until the output pin changes; irq must come with it
  task automatic wait_tog(output int d);
    logic last;
    last = pulse_out_pin;
    d = 0;
    do begin
      @(posedge clk_sys);
      #1 d++;
    end while (pulse_out_pin === last && d < 3000);
    chk(timer_irq, 1'b1);
  endtask

  initial begin
    #800000;
    n_fail++;
    report_and_stop();
  end

  initial begin
    v = $urandom(32'h29622bc2);
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    #1 chk(pulse_out_pin, 1'b1);
    chk(timer_irq, 1'b0);
    rd(OFS_CTRL, v);
    chk(v, 32'(CTRL_RESET));
    rd(8'h14, v);
    chk(v, 32'h0);
    $display("test reset done");
    for (int t = 2; t < 4; t++) begin
      hi_cyc <= 16'(8 + $urandom % 30);
      wr(OFS_CTRL, cw(1, t, 1, 0, 0, 0));
      src_run <= 1'b1;
      for (int k = 0; k < 3; k++) begin
        wait_irq();
        rd(OFS_CMPB, cap[k]);
      end
      rd(OFS_COUNT, v);
      chk(v, 32'h1);
      rd(OFS_STATUS, v);
      chk(v, 32'h5);
      chk(cap[1], cap[0] + 1);
      chk(cap[2], t == 2 ? hi_cyc : lo_cyc);
      src_run <= 1'b0;
      wr(OFS_CTRL, 32'h0);
    end
    $display("test single capture done");
    wr(OFS_CTRL, cw(1, 2, 0, 0, 0, 0));
    src_run <= 1'b1;
    for (int k = 0; k < 5; k++) begin
      wait_irq();
      rd(OFS_CMPB, cap[k]);
    end
    chk(cap[3] - cap[2], 32'(lo_cyc));
    chk(cap[4], cap[2]);
    src_run <= 1'b0;
    wr(OFS_CTRL, 32'h0);
    $display("test double capture done");
    for (int ck = 0; ck < 4; ck++) begin
      b = 2 + $urandom % 5;
      a = b + 3 + $urandom % 6;
      wr(OFS_CTRL, cw(2, 0, 0, 0, 0, ck));
      wr(OFS_CMPA, 32'(a));
      wr(OFS_CMPB, 32'(b));
      wr(OFS_CTRL, cw(2, 1, 0, 0, 0, ck));
      exp_q.push_back((a - b) * DIVS[ck]);
      exp_q.push_back((b + 1) * DIVS[ck]);
      wait_tog(dur);
      chk(pulse_out_pin, 1'b0);
      wait_tog(dur);
      chk(dur, exp_q.pop_front());
      wait_tog(dur);
      chk(dur, exp_q.pop_front());
      wr(OFS_CTRL, cw(2, 0, 0, 0, 0, ck));
      repeat (40) @(posedge clk_sys);
      #1 chk(pulse_out_pin, 1'b0);
      wr(OFS_CTRL, 32'h0);
    end
    $display("test continuous pulse done");
    wr(OFS_CTRL, cw(2, 0, 0, 0, 1, 0));
    repeat (2) @(posedge clk_sys);
    #1 chk(pulse_out_pin, 1'b0);
    wr(OFS_CMPA, 32'h9);
    wr(OFS_CMPB, 32'h4);
    wr(OFS_CTRL, cw(2, 2, 0, 1, 1, 0));
    repeat (30) @(posedge clk_sys);
    src_run <= 1'b1;
    #1 chk(pulse_out_pin, 1'b0);
    wait_tog(dur);
    wait_tog(dur);
    chk(dur, 32'h5);
    rd(OFS_CTRL, v);
    chk(v[3:2], START_STOP);
    repeat (50) @(posedge clk_sys);
    #1 chk(pulse_out_pin, 1'b0);
    src_run <= 1'b0;
    $display("test one-shot done");
    wr(OFS_CTRL, 32'h0);
    wr(OFS_CTRL, cw(2, 0, 0, 0, 0, 0));
    wr(OFS_CTRL, cw(2, 1, 0, 0, 0, 0));
    wait_tog(dur);
    @(posedge clk_sys);
    stop_mode_req <= 1'b1;
    @(posedge clk_sys);
    stop_mode_req <= 1'b0;
    rd(OFS_CTRL, v);
    chk(v[3:2], START_STOP);
    rd(OFS_COUNT, v);
    chk(v, 32'h0);
    chk(pulse_out_pin, 1'b0);
    $display("test stop mode done");
    report_and_stop();
  end
endmodule // tpm_bench
